// ### hw/board_reset_sequencer.sv
// board hard reset and user reset sequencer
// Functional notes
// R1 - hard reset holds board while supply bad
// R2 - hard reset unconfigures FPGAs, asserts card reset
// R3 - hard reset only from its own button
// R4 - any supply out of window triggers
// R5 - hold hard reset 55 us after triggers
// R6 - disable configuration and USB, clear controller logic
// R7 - on release, controller reinitialises and reconfigures
// R8 - user reset low at least 200 ns
// R9 - user reset from button or USB request
// R10 - user reset also asserts card reset
// R11 - no user reset indicator output
// R12 - user FPGAs handle reset internally
// R13 - multi-FPGA sync reset via shared line
// R14 - buttons synchronised and debounced
`timescale 1ns/1ps
`include "board_reset_consts.svh"
module board_reset_sequencer #(
	parameter int unsigned HOLD_CYCLES = `HARD_HOLD_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [`SUPPLY_COUNT-1:0] SUPPLY_GOOD,
	input wire board_reset_pkg::buttons_type BUTTONS_N,
	input wire logic USB_RESET_REQUEST,
	output logic CONFIG_LOGIC_RESET_N,
	output logic USB_ENABLE,
	output logic CONFIG_ENABLE,
	output logic FPGA_UNCONFIGURE_N,
	output logic CONTROLLER_REINIT,
	output logic [`FPGA_COUNT-1:0] FPGA_USER_RESET_N,
	output logic [`CARD_COUNT-1:0] DAUGHTERCARD_RESET_N,
	output logic HARD_RESET_INDICATOR
);
	logic [`SUPPLY_COUNT-1:0] sup1, sup2, sup3;
	logic [`SUPPLY_COUNT-1:0] supply_ok, next_supply_ok;
	logic supply_fault;
	logic hard_btn, user_btn, user_btn_q;
	logic usb_q;
	logic hard_trigger, user_trigger;
	board_reset_pkg::hard_state_type hard_state, next_hard_state;
	board_reset_pkg::user_state_type user_state, next_user_state;
	logic [`CNT_W-1:0] hold_cnt, next_hold_cnt;
	logic [`CNT_W-1:0] pulse_cnt, next_pulse_cnt;
	logic hard_on, user_on, next_reinit, exit_pulse;
	logic [`CNT_W-1:0] quiet_cnt, next_quiet_cnt;
	logic next_logic_reset_n, next_usb_enable, next_config_enable, next_unconfigure_n;
	logic next_controller_reinit, next_indicator;
	logic [`FPGA_COUNT-1:0] next_user_reset_n;
	logic [`CARD_COUNT-1:0] next_card_reset_n;

	// debounced buttons, pressed is low on the pins
	button_filter #(.SETTLE(DEBOUNCE_CYCLES)) hard_filter (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.raw(~BUTTONS_N.hard_reset_button),
		.level(hard_btn)
	);
	button_filter #(.SETTLE(DEBOUNCE_CYCLES)) user_filter (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.raw(~BUTTONS_N.user_reset_button),
		.level(user_btn)
	);

	// supply monitor synchroniser; reset state assumes faulted supplies
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sup1 <= '0;
			sup2 <= '0;
			sup3 <= '0;
			supply_ok <= '0;
		end else begin
			sup1 <= SUPPLY_GOOD;
			sup2 <= sup1;
			sup3 <= sup2;
			supply_ok <= next_supply_ok;
		end
	end
	// a rail changes state only once stages two and three agree, both ways
	always_comb begin
		next_supply_ok = supply_ok;
		for (int i = 0; i < `SUPPLY_COUNT; i++) begin
			if (sup2[i] == sup3[i]) begin
				next_supply_ok[i] = sup3[i];
			end
		end
	end
	// any rail out of its window is a fault
	assign supply_fault = ~&supply_ok; // R4

	// hard trigger: supplies or the dedicated button, never USB
	assign hard_trigger = supply_fault | hard_btn; // R1 R3

	// hard reset state machine with post-trigger hold
	always_comb begin
		next_hard_state = hard_state;
		next_hold_cnt = hold_cnt;
		next_reinit = 1'b0;
		case (hard_state)
			board_reset_pkg::HARD_ACTIVE: begin
				next_hold_cnt = '0;
				if (!hard_trigger) begin
					next_hard_state = board_reset_pkg::HARD_HOLD;
				end
			end
			board_reset_pkg::HARD_HOLD: begin
				if (hard_trigger) begin
					next_hard_state = board_reset_pkg::HARD_ACTIVE; // R5
					next_hold_cnt = '0;
				end else if (hold_cnt >= `CNT_W'(HOLD_CYCLES - 1)) begin
					next_hard_state = board_reset_pkg::HARD_IDLE;
					next_reinit = 1'b1; // R7
				end else begin
					next_hold_cnt = hold_cnt + `CNT_W'(1);
				end
			end
			board_reset_pkg::HARD_IDLE: begin
				if (hard_trigger) begin
					next_hard_state = board_reset_pkg::HARD_ACTIVE;
				end
			end
			default: begin
				next_hard_state = board_reset_pkg::HARD_ACTIVE;
			end
		endcase
	end
	// hard reset registers, power-up lands in reset
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			hard_state <= board_reset_pkg::HARD_ACTIVE;
			hold_cnt <= '0;
			exit_pulse <= 1'b0;
		end else begin
			hard_state <= next_hard_state;
			hold_cnt <= next_hold_cnt;
			exit_pulse <= next_reinit;
		end
	end
	assign hard_on = (hard_state != board_reset_pkg::HARD_IDLE);

	// cycles since the last trigger cleared, saturating; feeds the hold checks
	always_comb begin
		next_quiet_cnt = quiet_cnt;
		if (hard_trigger) begin
			next_quiet_cnt = '0;
		end else if (quiet_cnt < `CNT_W'(HOLD_CYCLES + 1)) begin
			next_quiet_cnt = quiet_cnt + `CNT_W'(1);
		end
	end
	// hold check counter register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			quiet_cnt <= '0;
		end else begin
			quiet_cnt <= next_quiet_cnt;
		end
	end

	// request edges: button press or USB vendor request pulse
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			user_btn_q <= 1'b0;
			usb_q <= 1'b0;
		end else begin
			user_btn_q <= user_btn;
			usb_q <= USB_RESET_REQUEST;
		end
	end
	assign user_trigger = (user_btn & ~user_btn_q) | (USB_RESET_REQUEST & ~usb_q); // R9

	// user reset pulse machine; waits for button release before rearming
	always_comb begin
		next_user_state = user_state;
		next_pulse_cnt = pulse_cnt;
		case (user_state)
			board_reset_pkg::USER_IDLE: begin
				next_pulse_cnt = '0;
				if (user_trigger && !hard_on) begin
					next_user_state = board_reset_pkg::USER_PULSE;
				end
			end
			board_reset_pkg::USER_PULSE: begin
				if (pulse_cnt >= `CNT_W'(`USER_PULSE_CYCLES - 1)) begin
					next_user_state = board_reset_pkg::USER_WAIT; // R8
				end else begin
					next_pulse_cnt = pulse_cnt + `CNT_W'(1);
				end
			end
			board_reset_pkg::USER_WAIT: begin
				if (!user_btn) begin
					next_user_state = board_reset_pkg::USER_IDLE;
				end
			end
			default: begin
				next_user_state = board_reset_pkg::USER_IDLE;
			end
		endcase
	end
	// user reset registers
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			user_state <= board_reset_pkg::USER_IDLE;
			pulse_cnt <= '0;
		end else begin
			user_state <= next_user_state;
			pulse_cnt <= next_pulse_cnt;
		end
	end
	assign user_on = (user_state == board_reset_pkg::USER_PULSE);

	// output next values; one shared level so all FPGAs release together
	always_comb begin
		next_logic_reset_n = ~hard_on; // R1 R6
		next_usb_enable = ~hard_on; // R6
		next_config_enable = ~hard_on; // R6
		next_unconfigure_n = ~hard_on; // R2
		next_controller_reinit = exit_pulse; // R7
		next_user_reset_n = {`FPGA_COUNT{~user_on}}; // R8
		next_card_reset_n = {`CARD_COUNT{~(hard_on | user_on)}}; // R2 R10
		next_indicator = hard_on; // R11
	end
	// output registers; reinit lands with the release of the reset outputs
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CONFIG_LOGIC_RESET_N <= 1'b0;
			USB_ENABLE <= 1'b0;
			CONFIG_ENABLE <= 1'b0;
			FPGA_UNCONFIGURE_N <= 1'b0;
			CONTROLLER_REINIT <= 1'b0;
			FPGA_USER_RESET_N <= '0;
			DAUGHTERCARD_RESET_N <= '0;
			HARD_RESET_INDICATOR <= 1'b1;
		end else begin
			CONFIG_LOGIC_RESET_N <= next_logic_reset_n;
			USB_ENABLE <= next_usb_enable;
			CONFIG_ENABLE <= next_config_enable;
			FPGA_UNCONFIGURE_N <= next_unconfigure_n;
			CONTROLLER_REINIT <= next_controller_reinit;
			FPGA_USER_RESET_N <= next_user_reset_n;
			DAUGHTERCARD_RESET_N <= next_card_reset_n;
			HARD_RESET_INDICATOR <= next_indicator;
		end
	end

	// checks
	sequence user_start_s;
		$rose(user_on);
	endsequence
	sequence user_low_s;
		!FPGA_USER_RESET_N[0] [*2];
	endsequence
	hard_hold_min_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
		$fell(hard_trigger) ##1 !hard_trigger [*8] |-> hard_on)
		else $error("hard reset released too soon");
	user_width_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
		user_start_s |=> user_low_s)
		else $error("user reset shorter than minimum");
	user_equal_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
		FPGA_USER_RESET_N == {`FPGA_COUNT{FPGA_USER_RESET_N[0]}})
		else $error("user resets not simultaneous");
	hard_card_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R2
		hard_on |=> DAUGHTERCARD_RESET_N == '0 && !FPGA_UNCONFIGURE_N)
		else $error("card reset missing in hard reset");
	user_card_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R10
		user_on |=> DAUGHTERCARD_RESET_N == '0)
		else $error("card reset missing in user reset");
	supply_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R1
		supply_fault |=> hard_on ##1 !CONFIG_LOGIC_RESET_N)
		else $error("supply fault did not hold reset");
	usb_block_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R6
		hard_on |=> !USB_ENABLE && !CONFIG_ENABLE)
		else $error("usb or config enabled in hard reset");
	reinit_exit_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R7
		$fell(hard_on) |=> CONTROLLER_REINIT)
		else $error("no reinit on hard reset exit");
	usb_user_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R9
		$rose(USB_RESET_REQUEST) && !hard_on && user_state == board_reset_pkg::USER_IDLE |=> user_on)
		else $error("usb request did not start user reset");
	indicator_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R11
		##1 HARD_RESET_INDICATOR == $past(hard_on))
		else $error("indicator does not follow hard reset");
	// hold timing checks
	hold_count_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
		!hard_trigger && quiet_cnt < `CNT_W'(HOLD_CYCLES) |-> hard_on)
		else $error("hard reset released before hold time");
	hold_release_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R5
		!hard_trigger && quiet_cnt == `CNT_W'(HOLD_CYCLES + 1) |-> !hard_on)
		else $error("hard reset held past hold time");
	// entry and exit checks
	no_remote_hard_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R3
		!hard_on && !hard_trigger |=> !hard_on)
		else $error("hard reset entered without a local trigger");
	button_user_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R9
		$rose(user_btn) && !hard_on && user_state == board_reset_pkg::USER_IDLE |=> user_on)
		else $error("user button did not start user reset");
	user_release_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R8
		user_start_s |=> user_low_s ##1 FPGA_USER_RESET_N[0])
		else $error("user reset not released after two cycles");
	reinit_once_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // R7
		CONTROLLER_REINIT |-> $past(hard_on, 2) && !$past(hard_on))
		else $error("reinit without a hard reset exit");
endmodule

// ### shared/board_reset_consts.svh
// constants for the board reset sequencer
`ifndef BOARD_RESET_CONSTS_SVH
`define BOARD_RESET_CONSTS_SVH
`define CLK_PERIOD_NS 100
`define HARD_HOLD_US 55
`define HARD_HOLD_CYCLES ((`HARD_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define USER_PULSE_NS 200
`define USER_PULSE_CYCLES ((`USER_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_US 5000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_US * 1000) / `CLK_PERIOD_NS)
`define SUPPLY_COUNT 7
`define FPGA_COUNT 16
`define CARD_COUNT 4
`define CNT_W 16
`endif

// ### shared/board_reset_pkg.sv
// types for the board reset sequencer
package board_reset_pkg;
	typedef enum logic [1:0] {HARD_ACTIVE, HARD_HOLD, HARD_IDLE} hard_state_type;
	typedef enum logic [1:0] {USER_IDLE, USER_PULSE, USER_WAIT} user_state_type;
	typedef struct packed {
		logic hard_reset_button;
		logic user_reset_button;
	} buttons_type;
endpackage

// ### hw/button_filter.sv
// three-stage synchroniser and debounce for one button
`timescale 1ns/1ps
`include "board_reset_consts.svh"
module button_filter #(
	parameter int unsigned SETTLE = `DEBOUNCE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic raw,
	output logic level
);
	logic s1, s2, s3;
	logic [`CNT_W-1:0] cnt, next_cnt;
	logic next_level;
	// next debounced level and counter
	always_comb begin
		next_cnt = cnt;
		next_level = level;
		if (s2 != s3 || s3 == level) begin
			next_cnt = '0;
		end else if (cnt >= `CNT_W'(SETTLE - 1)) begin
			next_level = s3; // R14
			next_cnt = '0;
		end else begin
			next_cnt = cnt + `CNT_W'(1);
		end
	end
	// synchroniser chain and state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			cnt <= '0;
			level <= 1'b0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			cnt <= next_cnt;
			level <= next_level;
		end
	end
endmodule

// ### verification/reset_receiver.sv
// model of the user fpgas and cards that see the reset lines
`timescale 1ns/1ps
module reset_receiver (
	input wire logic clk,
	input wire logic [15:0] fpga_reset_n,
	input wire logic [3:0] card_reset_n,
	output int pulses,
	output int width,
	output bit skew
);
	int run;
	logic [1:0] regen = 2'h0;
	logic shared_interfpga_line;
	// fpga 0 regenerates a synchronous reset for the shared inter-fpga line
	always @(posedge clk) begin
		regen <= {regen[0], fpga_reset_n[0]};
	end
	assign shared_interfpga_line = regen[1];
	// each receiver takes the reset from a plain input; all must agree
	always @(posedge clk) begin
		skew <= skew | (fpga_reset_n != 16'h0 && fpga_reset_n != 16'hFFFF)
			| (fpga_reset_n == 16'h0 && card_reset_n != 4'h0);
	end
	// pulses and widths timed on the regenerated shared line
	always @(posedge clk) begin
		if (shared_interfpga_line !== 1'b1) begin
			run <= run + 1;
		end else begin
			if (run != 0) begin
				pulses <= pulses + 1;
				width <= run;
			end
			run <= 0;
		end
	end
endmodule

// ### verification/tb.sv
// self-checking bench for the board reset sequencer
`timescale 1ns/1ps
module tb;
	localparam int HOLD = 8;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] supply_good = 7'h7F;
	board_reset_pkg::buttons_type buttons_n = 2'h3;
	logic usb_req = 1'b0;
	logic cfg_rst_n, usb_en, cfg_en, unconf_n, reinit, indicator;
	logic [15:0] user_n;
	logic [3:0] card_n;
	wire logic [15:0] hard_obs = {11'h0, cfg_rst_n, usb_en, cfg_en, unconf_n, indicator};
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	int pulses, width;
	bit skew;
	logic [31:0] seed = 32'h000107DF;

	board_reset_sequencer #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(4)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.SUPPLY_GOOD(supply_good), .BUTTONS_N(buttons_n), .USB_RESET_REQUEST(usb_req),
		.CONFIG_LOGIC_RESET_N(cfg_rst_n), .USB_ENABLE(usb_en), .CONFIG_ENABLE(cfg_en),
		.FPGA_UNCONFIGURE_N(unconf_n), .CONTROLLER_REINIT(reinit), .FPGA_USER_RESET_N(user_n),
		.DAUGHTERCARD_RESET_N(card_n), .HARD_RESET_INDICATOR(indicator));
	reset_receiver far (.clk(clk_sys), .fpga_reset_n(user_n), .card_reset_n(card_n),
		.pulses(pulses), .width(width), .skew(skew));

	// 10 MHz clock
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected hard reset outputs: config reset, usb, config, unconfigure, indicator
	function automatic logic [15:0] hard_vec(bit on);
		return on ? 16'h0001 : 16'h001E;
	endfunction

	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wait_reinit();
		int n = 0;
		while (reinit !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		chk("reinit", 16'h1, {15'h0, reinit});
		chk("hard off", hard_vec(1'b0), hard_obs);
		@(negedge clk_sys);
		chk("reinit end", 16'h0, {15'h0, reinit});
	endtask

	// supply bit k, or the hard button for k of 7
	task automatic hard_trig(int k);
		int n = 0;
		@(posedge clk_sys);
		if (k < 7) begin
			supply_good[k] <= 1'b0;
		end else begin
			buttons_n.hard_reset_button <= 1'b0;
		end
		repeat (12 + rnd() % 8) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("hard on", hard_vec(1'b1), hard_obs);
		chk("card hard", 16'h0, {12'h0, card_n});
		@(posedge clk_sys);
		supply_good <= 7'h7F;
		buttons_n.hard_reset_button <= 1'b1;
		while (indicator !== 1'b0 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		chk("hold", 16'h1, {15'h0, n >= HOLD && n <= HOLD + 12});
		wait_reinit();
	endtask

	// usb edge, optionally a second one inside the pulse, or the user button
	task automatic user_req(bit button, bit twice);
		int p = pulses;
		@(posedge clk_sys);
		if (button) begin
			buttons_n.user_reset_button <= 1'b0;
		end else begin
			usb_req <= 1'b1;
		end
		repeat (button ? 12 : 1) @(posedge clk_sys);
		buttons_n.user_reset_button <= 1'b1;
		usb_req <= 1'b0;
		if (twice && !button) begin
			@(posedge clk_sys);
			usb_req <= 1'b1;
			@(posedge clk_sys);
			usb_req <= 1'b0;
		end
		repeat (10 + rnd() % 8) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("pulses", 16'(p + 1), 16'(pulses));
		chk("width", 16'h2, 16'(width));
		chk("skew", 16'h0, {15'h0, skew});
		chk("indicator", 16'h0, {15'h0, indicator});
	endtask

	// hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			print_verdict();
		end
	end

	initial begin
		logic [31:0] r;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_reinit();
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			hard_trig(i);
			user_req(r[0], r[1]);
		end
		user_req(1'b1, 1'b0);
		print_verdict();
	end
endmodule
